/* File: include/bwsr_pkg.sv */
// Constants for the bridge window and secondary status register bank.
// Assumes an APB master on pclk and secondary bus event inputs already on pclk.
package bwsr_pkg;

   // Register byte offsets on the APB side.
   localparam logic [7:0] BWSR_OFF_IO_SEC      = 8'h1c;
   localparam logic [7:0] BWSR_OFF_MEM         = 8'h20;
   localparam logic [7:0] BWSR_OFF_PREF        = 8'h24;
   localparam logic [7:0] BWSR_OFF_PREF_BASE_UP = 8'h28;
   localparam logic [7:0] BWSR_OFF_PREF_LIM_UP = 8'h2c;
   localparam logic [7:0] BWSR_OFF_IO_UP       = 8'h30;
   localparam logic [7:0] BWSR_OFF_CTRL        = 8'h40;
   localparam logic [7:0] BWSR_OFF_IRQ_STAT    = 8'h44;
   localparam logic [7:0] BWSR_OFF_IRQ_CLR     = 8'h48;
   localparam logic [7:0] BWSR_OFF_IRQ_EN      = 8'h4c;

   // Fixed read-only encodings.
   localparam logic [3:0] BWSR_IO_DECODE_32    = 4'h1;
   localparam logic [3:0] BWSR_PREF_DECODE_64  = 4'h1;
   localparam logic [1:0] BWSR_SEL_TIMING_MED  = 2'h1;
   localparam logic [0:0] BWSR_CAP_66MHZ       = 1'h1;
   localparam logic [0:0] BWSR_CAP_FAST_B2B    = 1'h1;

   // Implied low address bits of window bounds.
   localparam logic [11:0] BWSR_IO_LOW_ZERO    = 12'h000;
   localparam logic [11:0] BWSR_IO_LOW_ONES    = 12'hfff;
   localparam logic [19:0] BWSR_MEM_LOW_ZERO   = 20'h0_0000;
   localparam logic [19:0] BWSR_MEM_LOW_ONES   = 20'hf_ffff;

   // Event vector positions; status and interrupt registers share the layout.
   localparam int BWSR_NUM_EV     = 6;
   localparam int BWSR_EV_DPE     = 0;
   localparam int BWSR_EV_STA     = 1;
   localparam int BWSR_EV_RTA     = 2;
   localparam int BWSR_EV_RMA     = 3;
   localparam int BWSR_EV_SERR    = 4;
   localparam int BWSR_EV_PERR    = 5;

   // Field positions inside the 1Ch word.
   localparam int BWSR_SEC_DPE_BIT = 24;
   localparam int BWSR_SEC_HI_LSB  = 27;

   // Own control register: parity error response enable.
   localparam int BWSR_CTRL_PAR_RESP_BIT = 6;

   // Values after reset.
   localparam logic [3:0]  BWSR_RST_NIBBLE = 4'h0;
   localparam logic [11:0] BWSR_RST_FIELD12 = 12'h000;
   localparam logic [15:0] BWSR_RST_HALF   = 16'h0000;
   localparam logic [31:0] BWSR_RST_WORD   = 32'h0000_0000;
   localparam logic [5:0]  BWSR_RST_EV     = 6'h00;

endpackage

/* File: testbench/bwsr_regs_checker.sv */
// Concurrent checks on the window and secondary status register bank.
// Assumes it is bound to bwsr_regs and sees only that module's ports.
module bwsr_regs_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic [63:0] fwd_addr,
   input wire logic        fwd_io_hit,
   input wire logic        fwd_mem_hit
);
   timeunit 1ns;
   timeprecision 100ps;
   wire logic rd_done;
   wire logic rd_sec;
   wire logic rd_mem;
   wire logic rd_pref;
   assign rd_done = psel & penable & pready & ~pwrite;
   assign rd_sec  = rd_done & (paddr == 8'h1c);
   assign rd_mem  = rd_done & (paddr == 8'h20);
   assign rd_pref = rd_done & (paddr == 8'h24);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   io_decode_a: assert property (rd_sec |-> prdata[11:8] == 4'h1)
      else $error("io decode field wrong");
   cap_66_a: assert property (rd_sec |-> prdata[21])
      else $error("66 MHz capability bit low");
   cap_b2b_a: assert property (rd_sec |-> prdata[23])
      else $error("fast back to back bit low");
   sel_timing_a: assert property (rd_sec |-> prdata[26:25] == 2'h1)
      else $error("select timing field wrong");
   pref_decode_a: assert property (rd_pref |-> prdata[3:0] == 4'h1)
      else $error("prefetch decode field wrong");
   sec_reserved_a: assert property (rd_sec |-> !prdata[22] && prdata[20:16] == 5'h00)
      else $error("status reserved bits set");
   mem_reserved_a: assert property
      (rd_mem |-> prdata[19:16] == 4'h0 && prdata[3:0] == 4'h0)
      else $error("memory reserved bits set");
   // Hits are registered, so the address that caused one is one cycle back.
   wide_miss_a: assert property
      (fwd_io_hit || fwd_mem_hit |-> $past(fwd_addr) < 64'h1_0000_0000)
      else $error("window hit above four gigabytes");
endmodule
bind bwsr_regs bwsr_regs_checker bwsr_regs_checker_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .fwd_addr(fwd_addr),
   .fwd_io_hit(fwd_io_hit), .fwd_mem_hit(fwd_mem_hit));

/* File: testbench/bwsr_sec_bus_model.sv */
// Secondary bus devices that raise error and abort events toward the bridge.
// Assumes the bench requests each event as a one-cycle bit of ev_req.
module bwsr_sec_bus_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [6:0] ev_req,
   output logic            secondary_parity_error_pin_n,
   output logic            secondary_system_error_pin_n,
   output logic            sec_target_abort_signaled,
   output logic            sec_target_abort_received,
   output logic            sec_master_abort_received,
   output logic            sec_addr_parity_error,
   output logic            sec_data_parity_error
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [6:0] ev_reg;
   // The error pins are active low and are driven back high between events.
   assign secondary_parity_error_pin_n = ~ev_reg[0];
   assign secondary_system_error_pin_n = ~ev_reg[1];
   assign sec_target_abort_signaled    = ev_reg[2];
   assign sec_target_abort_received    = ev_reg[3];
   assign sec_master_abort_received    = ev_reg[4];
   assign sec_addr_parity_error        = ev_reg[5];
   assign sec_data_parity_error        = ev_reg[6];
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ev_reg <= 7'h00;
      else
         ev_reg <= ev_req;
   end
endmodule

/* File: testbench/tb_bwsr_regs.sv */
// Self-checking bench for the window and secondary status register bank.
// Assumes one APB wait state and a far side model that turns requests into events.
module tb_bwsr_regs import bwsr_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] SEC_FIXED = 32'h02a0_0101;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [6:0]  ev_req = 7'h00;
   logic [63:0] fwd_addr = 64'h0000_0000_0000_0000;
   logic        fwd_is_io = 1'b0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, irq, err, io_hit, mem_hit, pref_hit;
   logic        perr_n, serr_n, sta, rta, rma, ape, dpe;
   int          n_mismatch = 0, n_tests = 0, cyc = 0;
   always #2 pclk = ~pclk;
   bwsr_regs bwsr_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .secondary_parity_error_pin_n(perr_n),
      .secondary_system_error_pin_n(serr_n), .sec_target_abort_signaled(sta),
      .sec_target_abort_received(rta), .sec_master_abort_received(rma),
      .sec_addr_parity_error(ape), .sec_data_parity_error(dpe), .fwd_addr(fwd_addr),
      .fwd_is_io(fwd_is_io), .fwd_io_hit(io_hit), .fwd_mem_hit(mem_hit),
      .fwd_pref_hit(pref_hit), .irq(irq));
   bwsr_sec_bus_model bwsr_sec_bus_model_i (.pclk(pclk), .presetn(presetn), .ev_req(ev_req),
      .secondary_parity_error_pin_n(perr_n), .secondary_system_error_pin_n(serr_n),
      .sec_target_abort_signaled(sta), .sec_target_abort_received(rta),
      .sec_master_abort_received(rma), .sec_addr_parity_error(ape),
      .sec_data_parity_error(dpe));
   task automatic results();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Values before the edge are read right after it, so the slave's updates never race.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp, what);
   endtask
   task automatic pulse(input logic [6:0] m);
      @(posedge pclk);
      ev_req <= m;
      @(posedge pclk);
      ev_req <= 7'h00;
      repeat (3) @(posedge pclk);
   endtask
   task automatic t_reset_rw();
      rdchk(BWSR_OFF_IO_SEC, SEC_FIXED, "sec reset");
      chk({31'h0, err}, 32'h0, "mapped read error");
      rdchk(BWSR_OFF_MEM, 32'h0000_0000, "mem reset");
      rdchk(BWSR_OFF_PREF, 32'h0001_0001, "pref reset");
      apb(1'b1, BWSR_OFF_IO_SEC, 32'hffff_ffff);
      apb(1'b1, BWSR_OFF_MEM, 32'hffff_ffff);
      apb(1'b1, BWSR_OFF_PREF, 32'hffff_ffff);
      rdchk(BWSR_OFF_IO_SEC, 32'h02a0_f1f1, "sec ones");
      rdchk(BWSR_OFF_MEM, 32'hfff0_fff0, "mem ones");
      rdchk(BWSR_OFF_PREF, 32'hfff1_fff1, "pref ones");
      rdchk(8'h50, 32'h0000_0000, "unmapped read");
      chk({31'h0, err}, 32'h1, "unmapped read error");
      apb(1'b1, 8'h50, 32'hffff_ffff);
      chk({31'h0, err}, 32'h1, "unmapped write error");
      $display("test reset and access done");
   endtask
   task automatic t_events();
      byte pos [7] = '{24, 30, 27, 28, 29, 31, 31};
      logic [31:0] base;
      base = 32'h02a0_f1f1;
      apb(1'b1, BWSR_OFF_CTRL, 32'h0000_0040);
      apb(1'b1, BWSR_OFF_IRQ_EN, 32'h0000_003f);
      for (int i = 0; i < 7; i++)
      begin
         pulse(7'(1 << i));
         rdchk(BWSR_OFF_IO_SEC, base | (32'h1 << pos[i]), "event set");
         chk({31'h0, irq}, 32'h1, "irq raised");
         apb(1'b1, BWSR_OFF_IO_SEC, 32'h0000_f0f0);
         rdchk(BWSR_OFF_IO_SEC, base | (32'h1 << pos[i]), "zero kept");
         apb(1'b1, BWSR_OFF_IO_SEC, 32'hf900_f0f0);
         apb(1'b1, BWSR_OFF_IRQ_CLR, 32'h0000_003f);
         rdchk(BWSR_OFF_IO_SEC, base, "one cleared");
         chk({31'h0, irq}, 32'h0, "irq cleared");
      end
      apb(1'b1, BWSR_OFF_CTRL, 32'h0000_0000);
      apb(1'b1, BWSR_OFF_IRQ_EN, 32'h0000_0000);
      pulse(7'h05);
      rdchk(BWSR_OFF_IO_SEC, base | 32'h0800_0000, "parity masked");
      chk({31'h0, irq}, 32'h0, "irq masked");
      apb(1'b1, BWSR_OFF_IRQ_EN, 32'h0000_003f);
      rdchk(BWSR_OFF_IRQ_CLR, 32'h0000_0000, "clear reads zero");
      chk({31'h0, irq}, 32'h1, "irq unmasked");
      rdchk(BWSR_OFF_IRQ_STAT, 32'h0000_0002, "int status");
      $display("test events done");
   endtask
   task automatic t_window();
      logic [63:0] adr [14] = '{64'h2000, 64'h3fff, 64'h1fff, 64'h4000, 64'h1000_0000,
         64'h1fff_ffff, 64'h0fff_ffff, 64'h2000_0000, 64'h1_1000_0000, 64'h1_1fff_ffff,
         64'h1_2000_0000, 64'h1_0000_2000, 64'h1_3fff, 64'h1_4000};
      logic [3:0]  ex [14] = '{4'hc, 4'hc, 4'h8, 4'hc, 4'h2, 4'h2, 4'h0, 4'h0, 4'h1, 4'h1,
         4'h0, 4'h8, 4'hc, 4'h8};
      apb(1'b1, BWSR_OFF_IO_SEC, 32'h0000_3020);
      apb(1'b1, BWSR_OFF_MEM, 32'h1ff0_1000);
      apb(1'b1, BWSR_OFF_PREF, 32'h1ff0_1000);
      apb(1'b1, BWSR_OFF_PREF_BASE_UP, 32'h0000_0001);
      apb(1'b1, BWSR_OFF_PREF_LIM_UP, 32'h0000_0001);
      // The I/O top moves up by the upper limit halfword, so 4000h now falls inside.
      apb(1'b1, BWSR_OFF_IO_UP, 32'h0001_0000);
      for (int i = 0; i < 14; i++)
      begin
         @(posedge pclk);
         fwd_addr <= adr[i];
         fwd_is_io <= ex[i][3];
         repeat (2) @(posedge pclk);
         chk(32'(io_hit), 32'(ex[i][2]), "io hit");
         chk(32'({mem_hit, pref_hit}), 32'(ex[i][1:0]), "mem hit");
      end
      $display("test windows done");
   endtask
   task automatic t_midreset();
      pulse(7'h02);
      rdchk(BWSR_OFF_IO_SEC, 32'h4aa0_3121, "sec before reset");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(BWSR_OFF_IO_SEC, SEC_FIXED, "sec after reset");
      rdchk(BWSR_OFF_MEM, 32'h0000_0000, "mem after reset");
      chk({31'h0, irq}, 32'h0, "irq after reset");
      $display("test mid-run reset done");
   endtask
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         results();
      end
   end
   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_rw();
      t_events();
      t_window();
      t_midreset();
      results();
   end
endmodule

/* File: verilog/bwsr_regs.sv */
// Window and secondary status register bank of a two-port bridge, as an APB slave.
// Assumes event inputs are synchronous to pclk and each is high one cycle per event;
// the error pins are active low levels sampled on every rising pclk edge.
//
// Chosen here: register access over APB.

// How it works
// RULE1: I/O limit bits 11:8 always read 1, meaning 32-bit I/O decoding.
// RULE2: I/O limit bits 15:12 give top address 15:12; low twelve bits are ones.
// RULE3: I/O window bottom has its low twelve address bits forced to zero.
// RULE4: I/O window top bits 31:16 come from the upper limit halfword.
// RULE5: Secondary status bit 21 is fixed at 1 for 66 MHz capability.
// RULE6: Secondary status bit 23 is fixed at 1 for fast back-to-back decoding.
// RULE7: Bit 24 sets on parity error pin while parity response enable is on.
// RULE8: Secondary status bits 26:25 read 01, medium select timing.
// RULE9: Bit 27 sets when the bridge as target signals target abort.
// RULE10: Bit 28 sets when a bridge-mastered cycle receives target abort.
// RULE11: Bit 29 sets when a bridge-mastered cycle ends in master abort.
// RULE12: Bit 30 sets whenever the secondary system error pin is asserted.
// RULE13: Bit 31 sets on any secondary address or data parity error.
// RULE14: Sticky status bits clear on writing one, ignore zero, reset to zero.
// RULE15: Memory base 15:4 gives bottom bits 31:20; low bits zero; resets zero.
// RULE16: Memory limit 31:20 gives top bits 31:20; low twenty bits are ones.
// RULE17: Prefetch base reads 0001 in 3:0; 15:4 gives base bits 31:20.
// RULE18: Prefetch top has low twenty bits ones, upper word separate.
// RULE19: Forward only inside inclusive base to limit; reserved bits read zero.
module bwsr_regs
   import bwsr_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        secondary_parity_error_pin_n,
   input  wire logic        secondary_system_error_pin_n,
   input  wire logic        sec_target_abort_signaled,
   input  wire logic        sec_target_abort_received,
   input  wire logic        sec_master_abort_received,
   input  wire logic        sec_addr_parity_error,
   input  wire logic        sec_data_parity_error,
   input  wire logic [63:0] fwd_addr,
   input  wire logic        fwd_is_io,
   output logic             fwd_io_hit,
   output logic             fwd_mem_hit,
   output logic             fwd_pref_hit,
   output logic             irq
);

   logic [3:0]             io_base_reg;
   logic [3:0]             io_lim_reg;
   logic [15:0]            io_base_up_reg;
   logic [15:0]            io_lim_up_reg;
   logic [11:0]            mem_base_reg;
   logic [11:0]            mem_lim_reg;
   logic [11:0]            pref_base_reg;
   logic [11:0]            pref_lim_reg;
   logic [31:0]            pref_base_up_reg;
   logic [31:0]            pref_lim_up_reg;
   logic                   par_resp_reg;
   logic [BWSR_NUM_EV-1:0] sticky_reg;
   logic [BWSR_NUM_EV-1:0] irq_stat_reg;
   logic [BWSR_NUM_EV-1:0] irq_en_reg;
   logic [31:0]            prdata_reg;
   logic                   pready_reg;
   logic                   pslverr_reg;
   logic                   io_hit_reg;
   logic                   mem_hit_reg;
   logic                   pref_hit_reg;
   logic                   irq_reg;

   // The slave inserts one wait state so read data and the error flag are registered.
   wire access   = psel & penable;
   wire complete = access & pready_reg;
   wire wr_fire  = complete & pwrite;

   wire sel_io_sec   = (paddr == BWSR_OFF_IO_SEC);
   wire sel_mem      = (paddr == BWSR_OFF_MEM);
   wire sel_pref     = (paddr == BWSR_OFF_PREF);
   wire sel_pbase_up = (paddr == BWSR_OFF_PREF_BASE_UP);
   wire sel_plim_up  = (paddr == BWSR_OFF_PREF_LIM_UP);
   wire sel_io_up    = (paddr == BWSR_OFF_IO_UP);
   wire sel_ctrl     = (paddr == BWSR_OFF_CTRL);
   wire sel_istat    = (paddr == BWSR_OFF_IRQ_STAT);
   wire sel_iclr     = (paddr == BWSR_OFF_IRQ_CLR);
   wire sel_ien      = (paddr == BWSR_OFF_IRQ_EN);
   wire mapped       = sel_io_sec | sel_mem | sel_pref | sel_pbase_up | sel_plim_up |
                       sel_io_up | sel_ctrl | sel_istat | sel_iclr | sel_ien;

   wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
   wire [31:0] wbits = pwdata & wmask;

   // Secondary bus events, one bit per sticky flag.
   wire [BWSR_NUM_EV-1:0] ev;
   // RULE7: parity pin gated
   assign ev[BWSR_EV_DPE]  = ~secondary_parity_error_pin_n & par_resp_reg;
   // RULE9: signaled target abort
   assign ev[BWSR_EV_STA]  = sec_target_abort_signaled;
   // RULE10: received target abort
   assign ev[BWSR_EV_RTA]  = sec_target_abort_received;
   // RULE11: received master abort
   assign ev[BWSR_EV_RMA]  = sec_master_abort_received;
   // RULE12: system error pin
   assign ev[BWSR_EV_SERR] = ~secondary_system_error_pin_n;
   // RULE13: address or data parity
   assign ev[BWSR_EV_PERR] = sec_addr_parity_error | sec_data_parity_error;

   // RULE14: write one clears
   wire [BWSR_NUM_EV-1:0] sticky_clr = {BWSR_NUM_EV{wr_fire & sel_io_sec}} &
                                       {wbits[31:BWSR_SEC_HI_LSB], wbits[BWSR_SEC_DPE_BIT]};
   // An event in the clearing cycle survives: set is applied after the clear.
   wire [BWSR_NUM_EV-1:0] sticky_next = (sticky_reg & ~sticky_clr) | ev;

   wire [BWSR_NUM_EV-1:0] istat_clr  = {BWSR_NUM_EV{wr_fire & sel_iclr}} &
                                       wbits[BWSR_NUM_EV-1:0];
   wire [BWSR_NUM_EV-1:0] istat_next = (irq_stat_reg & ~istat_clr) | ev;

   // Byte-lane merges for the writable fields.
   wire [3:0]  io_base_next  = (wr_fire & sel_io_sec & pstrb[0]) ? pwdata[7:4] : io_base_reg;
   // RULE2: writable limit nibble
   wire [3:0]  io_lim_next   = (wr_fire & sel_io_sec & pstrb[1]) ? pwdata[15:12] : io_lim_reg;
   // RULE15: base field write
   wire [11:0] mem_base_next = (wr_fire & sel_mem) ?
                               ((mem_base_reg & ~wmask[15:4]) | wbits[15:4]) : mem_base_reg;
   // RULE16: limit field write
   wire [11:0] mem_lim_next  = (wr_fire & sel_mem) ?
                               ((mem_lim_reg & ~wmask[31:20]) | wbits[31:20]) : mem_lim_reg;
   // RULE17: prefetch base write
   wire [11:0] pref_base_next = (wr_fire & sel_pref) ?
                               ((pref_base_reg & ~wmask[15:4]) | wbits[15:4]) : pref_base_reg;
   wire [11:0] pref_lim_next = (wr_fire & sel_pref) ?
                               ((pref_lim_reg & ~wmask[31:20]) | wbits[31:20]) : pref_lim_reg;
   wire [31:0] pbase_up_next = (wr_fire & sel_pbase_up) ?
                               ((pref_base_up_reg & ~wmask) | wbits) : pref_base_up_reg;
   wire [31:0] plim_up_next  = (wr_fire & sel_plim_up) ?
                               ((pref_lim_up_reg & ~wmask) | wbits) : pref_lim_up_reg;
   wire [15:0] io_base_up_next = (wr_fire & sel_io_up) ?
                               ((io_base_up_reg & ~wmask[15:0]) | wbits[15:0]) : io_base_up_reg;
   // RULE4: upper limit halfword
   wire [15:0] io_lim_up_next = (wr_fire & sel_io_up) ?
                               ((io_lim_up_reg & ~wmask[31:16]) | wbits[31:16]) : io_lim_up_reg;
   wire        par_resp_next = (wr_fire & sel_ctrl & pstrb[0]) ?
                               pwdata[BWSR_CTRL_PAR_RESP_BIT] : par_resp_reg;
   wire [BWSR_NUM_EV-1:0] irq_en_next = (wr_fire & sel_ien & pstrb[0]) ?
                               pwdata[BWSR_NUM_EV-1:0] : irq_en_reg;

   // Read words; reserved bits are tied to zero by the concatenations.
   // RULE1: 32-bit I/O indicator
   wire [15:0] rd_io_lo  = {io_lim_reg, BWSR_IO_DECODE_32, io_base_reg, BWSR_IO_DECODE_32};
   // RULE5: 66 MHz capable
   // RULE6: fast back-to-back capable
   // RULE8: medium select timing
   wire [15:0] rd_sec_hi = {sticky_reg[BWSR_NUM_EV-1:1], BWSR_SEL_TIMING_MED,
                            sticky_reg[BWSR_EV_DPE], BWSR_CAP_FAST_B2B, 1'b0,
                            BWSR_CAP_66MHZ, 5'h00};
   wire [31:0] rd_io_sec = {rd_sec_hi, rd_io_lo};
   // RULE19: reserved bits zero
   wire [31:0] rd_mem    = {mem_lim_reg, 4'h0, mem_base_reg, 4'h0};
   wire [31:0] rd_pref   = {pref_lim_reg, BWSR_PREF_DECODE_64, pref_base_reg,
                            BWSR_PREF_DECODE_64};
   wire [31:0] rd_io_up  = {io_lim_up_reg, io_base_up_reg};
   wire [31:0] rd_ctrl   = {25'h000_0000, par_resp_reg, 6'h00};
   wire [31:0] rd_istat  = {26'h000_0000, irq_stat_reg};
   wire [31:0] rd_ien    = {26'h000_0000, irq_en_reg};

   // The clear register is write-only and reads as zero.
   wire [31:0] rd_word = sel_io_sec   ? rd_io_sec :
                         sel_mem      ? rd_mem :
                         sel_pref     ? rd_pref :
                         sel_pbase_up ? pref_base_up_reg :
                         sel_plim_up  ? pref_lim_up_reg :
                         sel_io_up    ? rd_io_up :
                         sel_ctrl     ? rd_ctrl :
                         sel_istat    ? rd_istat :
                         sel_ien      ? rd_ien : BWSR_RST_WORD;

   wire pready_next = access & ~pready_reg;
   wire [31:0] prdata_next = (pready_next & ~pwrite) ? rd_word : BWSR_RST_WORD;
   wire pslverr_next = pready_next & ~mapped;

   // Assembled window bounds.
   // RULE3: bottom low bits zero
   wire [31:0] io_bottom  = {io_base_up_reg, io_base_reg, BWSR_IO_LOW_ZERO};
   wire [31:0] io_top     = {io_lim_up_reg, io_lim_reg, BWSR_IO_LOW_ONES};
   wire [31:0] mem_bottom = {mem_base_reg, BWSR_MEM_LOW_ZERO};
   wire [31:0] mem_top    = {mem_lim_reg, BWSR_MEM_LOW_ONES};
   wire [63:0] pref_bottom = {pref_base_up_reg, pref_base_reg, BWSR_MEM_LOW_ZERO};
   // RULE18: prefetch top ones
   wire [63:0] pref_top   = {pref_lim_up_reg, pref_lim_reg, BWSR_MEM_LOW_ONES};

   // RULE19: inclusive window compare
   wire io_hit_next   = fwd_is_io & (fwd_addr[63:32] == BWSR_RST_WORD) &
                        (fwd_addr[31:0] >= io_bottom) & (fwd_addr[31:0] <= io_top);
   wire mem_hit_next  = ~fwd_is_io & (fwd_addr[63:32] == BWSR_RST_WORD) &
                        (fwd_addr[31:0] >= mem_bottom) & (fwd_addr[31:0] <= mem_top);
   wire pref_hit_next = ~fwd_is_io & (fwd_addr >= pref_bottom) & (fwd_addr <= pref_top);

   wire irq_next = |(istat_next & irq_en_next);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= BWSR_RST_WORD;
      end
      else
      begin
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg  <= prdata_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         io_base_reg      <= BWSR_RST_NIBBLE;
         io_lim_reg       <= BWSR_RST_NIBBLE;
         io_base_up_reg   <= BWSR_RST_HALF;
         io_lim_up_reg    <= BWSR_RST_HALF;
         mem_base_reg     <= BWSR_RST_FIELD12;
         mem_lim_reg      <= BWSR_RST_FIELD12;
         pref_base_reg    <= BWSR_RST_FIELD12;
         pref_lim_reg     <= BWSR_RST_FIELD12;
         pref_base_up_reg <= BWSR_RST_WORD;
         pref_lim_up_reg  <= BWSR_RST_WORD;
         par_resp_reg     <= 1'b0;
      end
      else
      begin
         io_base_reg      <= io_base_next;
         io_lim_reg       <= io_lim_next;
         io_base_up_reg   <= io_base_up_next;
         io_lim_up_reg    <= io_lim_up_next;
         mem_base_reg     <= mem_base_next;
         mem_lim_reg      <= mem_lim_next;
         pref_base_reg    <= pref_base_next;
         pref_lim_reg     <= pref_lim_next;
         pref_base_up_reg <= pbase_up_next;
         pref_lim_up_reg  <= plim_up_next;
         par_resp_reg     <= par_resp_next;
      end
   end

   // RULE14: sticky flags reset zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sticky_reg   <= BWSR_RST_EV;
         irq_stat_reg <= BWSR_RST_EV;
         irq_en_reg   <= BWSR_RST_EV;
         irq_reg      <= 1'b0;
      end
      else
      begin
         sticky_reg   <= sticky_next;
         irq_stat_reg <= istat_next;
         irq_en_reg   <= irq_en_next;
         irq_reg      <= irq_next;
      end
   end

   // Hit flags lag the address by one cycle; the forwarding logic must allow for it.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         io_hit_reg   <= 1'b0;
         mem_hit_reg  <= 1'b0;
         pref_hit_reg <= 1'b0;
      end
      else
      begin
         io_hit_reg   <= io_hit_next;
         mem_hit_reg  <= mem_hit_next;
         pref_hit_reg <= pref_hit_next;
      end
   end

   assign prdata       = prdata_reg;
   assign pready       = pready_reg;
   assign pslverr      = pslverr_reg;
   assign fwd_io_hit   = io_hit_reg;
   assign fwd_mem_hit  = mem_hit_reg;
   assign fwd_pref_hit = pref_hit_reg;
   assign irq          = irq_reg;

endmodule
